// *** alm_pkg.sv ***
// Constants, types and register map of the acceleration limit monitor.
//
// Contract
// - Every 250 us step the speed difference between the current and previous sample is checked against the limits.
// - Eight limit sets are held and the one picked by the index select input is used for checking.
// - Monitoring is active only when both hardware activation inputs are high or the safe bus status enables it.
// - The monitoring state is shown in bit 9 of the status word.
// - The upper limit bounds speeding up and the lower limit bounds slowing down, in either rotation direction.
// - A difference above the upper or below the lower limit triggers the chosen safe torque off or safe stop one.
// - Activation and deactivation complete well within 4 ms of the activation condition changing.
// - A violation writes two log records, the trigger step with the fail-safe flag and the preceding step.
// - Each log record holds position, speed, a time stamp in 62.5 us units and a status word.
// - The position field of the preceding-step record holds the minimum signed 32-bit value.
package alm_pkg;

    // ------------------------------------------------------------------
    // Timing.
    // ------------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 40;
    localparam int unsigned STEP_TIME_NS  = 250_000;
    localparam int unsigned SLOT_TIME_NS  = 62_500;
    localparam int unsigned ACT_TIME_NS   = 4_000_000;
    localparam int unsigned STEP_CYC_DEF  = STEP_TIME_NS / CLK_PERIOD_NS;
    localparam int unsigned ACT_CYC_MAX   = ACT_TIME_NS / CLK_PERIOD_NS;
    localparam logic [31:0] STEP_SLOTS    = 32'(STEP_TIME_NS / SLOT_TIME_NS);
    localparam int unsigned LIM_SETS      = 8;

    // ------------------------------------------------------------------
    // Register map, byte addresses.
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL     = 8'h00;
    localparam logic [7:0] OFS_STATUS   = 8'h04;
    localparam logic [7:0] OFS_LIM_ADDR = 8'h08;
    localparam logic [7:0] OFS_LIM_DATA = 8'h0C;
    localparam logic [7:0] OFS_LOG0     = 8'h10;
    localparam logic [7:0] OFS_LOG1     = 8'h20;

    localparam int unsigned CTRL_BUS_ACT = 0;
    localparam int unsigned CTRL_ERR_SS1 = 1;
    localparam int unsigned CTRL_CLR     = 2;

    localparam int unsigned STAT_STO  = 0;
    localparam int unsigned STAT_SS1  = 2;
    localparam int unsigned STAT_LAM  = 9;
    localparam int unsigned STAT_FAIL = 16;

    localparam logic [31:0] POS_MIN  = 32'h8000_0000;
    localparam logic [31:0] WORD_RST = 32'h0000_0000;

    // ------------------------------------------------------------------
    // Types.
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [31:0] pos;
        logic [31:0] speed;
        logic [31:0] tstamp;
        logic [31:0] status;
    } alm_log_t;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_RDUP  = 2'b01,
        ST_RDLO  = 2'b10,
        ST_CHECK = 2'b11
    } alm_state_t;

endpackage

// *** alm_sync.sv ***
// Two-flop synchroniser for pin inputs.
module alm_sync #(
    parameter int unsigned W = 1
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic         ce_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] meta_q;
    logic [W-1:0] meta_d;
    logic [W-1:0] sync_q;
    logic [W-1:0] sync_d;

    always_comb begin
        meta_d = ce_i ? d_i : meta_q;
        sync_d = ce_i ? meta_q : sync_q;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign q_o = sync_q;
endmodule

// *** alm_lim_mem.sv ***
// Limit set memory with one write port and one registered read port.
module alm_lim_mem #(
    parameter int unsigned AW = 4,
    parameter int unsigned DW = 32
) (
    input  wire logic          clk_i,
    input  wire logic          ce_i,
    input  wire logic          we_i,
    input  wire logic [AW-1:0] waddr_i,
    input  wire logic [DW-1:0] wdata_i,
    input  wire logic [AW-1:0] raddr_i,
    output logic      [DW-1:0] rdata_o
);
    logic [DW-1:0] mem_q [2**AW];
    logic [DW-1:0] rdata_q;

    // No reset on the array: software must load every set it selects.
    always_ff @(posedge clk_i) begin
        if (ce_i) begin
            if (we_i) begin
                mem_q[waddr_i] <= wdata_i;
            end
            rdata_q <= mem_q[raddr_i];
        end
    end

    assign rdata_o = rdata_q;
endmodule

// *** alm_accel_mon.sv ***
// Acceleration limit monitor top with APB register access.
module alm_accel_mon
    import alm_pkg::*;
#(
    parameter int unsigned STEP_CYC = STEP_CYC_DEF,
    parameter int unsigned N_SETS   = LIM_SETS
) (
    input  wire logic        CLOCK_I,
    input  wire logic        SYS_RST_I,
    input  wire logic        CE_I,
    input  wire logic        PSEL_I,
    input  wire logic        PENABLE_I,
    input  wire logic        PWRITE_I,
    input  wire logic [7:0]  PADDR_I,
    input  wire logic [31:0] PWDATA_I,
    output logic             PREADY_O,
    output logic      [31:0] PRDATA_O,
    output logic             PSLVERR_O,
    input  wire logic        ACT_A_I,
    input  wire logic        ACT_B_I,
    input  wire logic [$clog2(N_SETS)-1:0] LIM_SEL_I,
    input  wire logic [31:0] SPEED_I,
    input  wire logic [31:0] POSITION_I,
    output logic             LAM_ACTIVE_O,
    output logic             SAFE_TORQUE_OFF_O,
    output logic             SAFE_STOP_ONE_O,
    output logic             FAIL_SAFE_O
);
    localparam int unsigned SW = $clog2(N_SETS);
    localparam int unsigned CW = $clog2(STEP_CYC);
    localparam logic [CW-1:0] CNT_LAST = CW'(STEP_CYC - 1);

    // ------------------------------------------------------------------
    // Pin synchronisers.
    // ------------------------------------------------------------------
    logic [SW+1:0] pins_s;
    logic          act_a_s;
    logic          act_b_s;
    logic [SW-1:0] sel_s;

    alm_sync #(.W(SW + 2)) u_sync (
        .clk_i (CLOCK_I),
        .rst_i (SYS_RST_I),
        .ce_i  (CE_I),
        .d_i   ({ACT_A_I, ACT_B_I, LIM_SEL_I}),
        .q_o   (pins_s)
    );
    assign {act_a_s, act_b_s, sel_s} = pins_s;

    // ------------------------------------------------------------------
    // APB slave and control registers.
    // ------------------------------------------------------------------
    logic          pready_q, pready_d;
    logic [31:0]   prdata_q, prdata_d;
    logic          pslverr_q, pslverr_d;
    logic          bus_act_q, bus_act_d;
    logic          err_ss1_q, err_ss1_d;
    logic [SW:0]   lim_addr_q, lim_addr_d;
    logic          acc, done, hit, mem_we, clr_req;
    logic [31:0]   rd_word;
    alm_log_t      log0_q, log0_d;
    alm_log_t      log1_q, log1_d;
    logic [31:0]   status_q, status_d;

    // The answer is one cycle late so that read data come from a flop.
    assign acc     = PSEL_I & PENABLE_I & ~pready_q;
    assign done    = PSEL_I & PENABLE_I & pready_q;
    assign mem_we  = done & PWRITE_I & (PADDR_I == OFS_LIM_DATA);
    assign clr_req = done & PWRITE_I & (PADDR_I == OFS_CTRL) & PWDATA_I[CTRL_CLR];

    always_comb begin
        hit     = 1'b1;
        rd_word = WORD_RST;
        case (PADDR_I)
            OFS_CTRL: begin
                rd_word[CTRL_BUS_ACT] = bus_act_q;
                rd_word[CTRL_ERR_SS1] = err_ss1_q;
            end
            OFS_STATUS:        rd_word = status_q;
            OFS_LIM_ADDR:      rd_word[SW:0] = lim_addr_q;
            OFS_LIM_DATA:      rd_word = WORD_RST;
            OFS_LOG0:          rd_word = log0_q.pos;
            OFS_LOG0 + 8'h04:  rd_word = log0_q.speed;
            OFS_LOG0 + 8'h08:  rd_word = log0_q.tstamp;
            OFS_LOG0 + 8'h0C:  rd_word = log0_q.status;
            OFS_LOG1:          rd_word = log1_q.pos;
            OFS_LOG1 + 8'h04:  rd_word = log1_q.speed;
            OFS_LOG1 + 8'h08:  rd_word = log1_q.tstamp;
            OFS_LOG1 + 8'h0C:  rd_word = log1_q.status;
            default:           hit = 1'b0;
        endcase
        pready_d  = acc;
        prdata_d  = acc ? (PWRITE_I ? WORD_RST : rd_word) : prdata_q;
        pslverr_d = acc ? ~hit : 1'b0;
        bus_act_d = bus_act_q;
        err_ss1_d = err_ss1_q;
        lim_addr_d = lim_addr_q;
        if (done & PWRITE_I & (PADDR_I == OFS_CTRL)) begin
            bus_act_d = PWDATA_I[CTRL_BUS_ACT];
            err_ss1_d = PWDATA_I[CTRL_ERR_SS1];
        end
        if (done & PWRITE_I & (PADDR_I == OFS_LIM_ADDR)) begin
            lim_addr_d = PWDATA_I[SW:0];
        end
    end

    always_ff @(posedge CLOCK_I) begin
        if (SYS_RST_I) begin
            pready_q   <= 1'b0;
            prdata_q   <= WORD_RST;
            pslverr_q  <= 1'b0;
            bus_act_q  <= 1'b0;
            err_ss1_q  <= 1'b0;
            lim_addr_q <= '0;
        end else if (CE_I) begin
            pready_q   <= pready_d;
            prdata_q   <= prdata_d;
            pslverr_q  <= pslverr_d;
            bus_act_q  <= bus_act_d;
            err_ss1_q  <= err_ss1_d;
            lim_addr_q <= lim_addr_d;
        end
    end

    // ------------------------------------------------------------------
    // Limit memory: word {set, 0} is upper, {set, 1} is lower.
    // ------------------------------------------------------------------
    alm_state_t  st_q, st_d;
    logic [SW:0] raddr;
    logic [31:0] rdata;

    assign raddr = {sel_s, (st_q == ST_RDLO)};

    alm_lim_mem #(.AW(SW + 1), .DW(32)) u_mem (
        .clk_i   (CLOCK_I),
        .ce_i    (CE_I),
        .we_i    (mem_we),
        .waddr_i (lim_addr_q),
        .wdata_i (PWDATA_I),
        .raddr_i (raddr),
        .rdata_o (rdata)
    );

    // ------------------------------------------------------------------
    // Step timing, comparison and reaction.
    // ------------------------------------------------------------------
    logic [CW-1:0]       cnt_q, cnt_d;
    logic [31:0]         ts_q, ts_d;
    logic [31:0]         cur_spd_q, cur_spd_d;
    logic [31:0]         cur_pos_q, cur_pos_d;
    logic [31:0]         prev_spd_q, prev_spd_d;
    logic                prev_ok_q, prev_ok_d;
    logic [31:0]         up_q, up_d;
    logic [31:0]         stat_prev_q, stat_prev_d;
    logic                act_q, act_d;
    logic                sto_q, sto_d;
    logic                ss1_q, ss1_d;
    logic                fault_q, fault_d;
    logic                tick, viol;
    logic signed [32:0]  diff, mag, up_s, lo_s;
    logic [31:0]         stat_now, stat_trig;

    assign tick = (cnt_q == CNT_LAST);
    assign diff = $signed({cur_spd_q[31], cur_spd_q}) - $signed({prev_spd_q[31], prev_spd_q});
    // Speeding up in reverse gives a negative difference, so it is mirrored.
    assign mag  = cur_spd_q[31] ? -diff : diff;
    assign up_s = $signed({up_q[31], up_q});
    assign lo_s = $signed({rdata[31], rdata});
    // The first step after reset has no previous sample and is not judged.
    assign viol = (st_q == ST_CHECK) & act_q & prev_ok_q & ((mag > up_s) | (mag < lo_s));

    always_comb begin
        stat_now = WORD_RST;
        stat_now[STAT_STO]  = sto_q;
        stat_now[STAT_SS1]  = ss1_q;
        stat_now[STAT_LAM]  = act_q;
        stat_now[STAT_FAIL] = fault_q;
        stat_trig = stat_now;
        stat_trig[STAT_FAIL] = 1'b1;
        stat_trig[STAT_STO]  = sto_q | ~err_ss1_q;
        stat_trig[STAT_SS1]  = ss1_q | err_ss1_q;
    end

    always_comb begin
        st_d        = st_q;
        cnt_d       = tick ? '0 : cnt_q + 1'b1;
        ts_d        = tick ? ts_q + STEP_SLOTS : ts_q;
        cur_spd_d   = cur_spd_q;
        cur_pos_d   = cur_pos_q;
        prev_spd_d  = prev_spd_q;
        prev_ok_d   = prev_ok_q;
        up_d        = up_q;
        stat_prev_d = stat_prev_q;
        log0_d      = log0_q;
        log1_d      = log1_q;
        // Path from pin to flag is three cycles, far inside the bound.
        act_d       = (act_a_s & act_b_s) | bus_act_q;
        // A new violation wins over a clear in the same cycle.
        sto_d       = (sto_q & ~clr_req) | (viol & ~err_ss1_q);
        ss1_d       = (ss1_q & ~clr_req) | (viol & err_ss1_q);
        fault_d     = (fault_q & ~clr_req) | viol;
        status_d    = stat_now;
        case (st_q)
            ST_IDLE: begin
                if (tick) begin
                    cur_spd_d = SPEED_I;
                    cur_pos_d = POSITION_I;
                    st_d      = ST_RDUP;
                end
            end
            ST_RDUP: st_d = ST_RDLO;
            ST_RDLO: begin
                up_d = rdata;
                st_d = ST_CHECK;
            end
            ST_CHECK: begin
                if (viol) begin
                    log0_d = '{cur_pos_q, cur_spd_q, ts_q, stat_trig};
                    log1_d = '{POS_MIN, prev_spd_q, ts_q - STEP_SLOTS, stat_prev_q};
                end
                prev_spd_d  = cur_spd_q;
                prev_ok_d   = 1'b1;
                stat_prev_d = stat_now;
                st_d        = ST_IDLE;
            end
            default: st_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge CLOCK_I) begin
        if (SYS_RST_I) begin
            st_q        <= ST_IDLE;
            cnt_q       <= '0;
            ts_q        <= WORD_RST;
            cur_spd_q   <= WORD_RST;
            cur_pos_q   <= WORD_RST;
            prev_spd_q  <= WORD_RST;
            prev_ok_q   <= 1'b0;
            up_q        <= WORD_RST;
            stat_prev_q <= WORD_RST;
            log0_q      <= '0;
            log1_q      <= '0;
            act_q       <= 1'b0;
            sto_q       <= 1'b0;
            ss1_q       <= 1'b0;
            fault_q     <= 1'b0;
            status_q    <= WORD_RST;
        end else if (CE_I) begin
            st_q        <= st_d;
            cnt_q       <= cnt_d;
            ts_q        <= ts_d;
            cur_spd_q   <= cur_spd_d;
            cur_pos_q   <= cur_pos_d;
            prev_spd_q  <= prev_spd_d;
            prev_ok_q   <= prev_ok_d;
            up_q        <= up_d;
            stat_prev_q <= stat_prev_d;
            log0_q      <= log0_d;
            log1_q      <= log1_d;
            act_q       <= act_d;
            sto_q       <= sto_d;
            ss1_q       <= ss1_d;
            fault_q     <= fault_d;
            status_q    <= status_d;
        end
    end

    assign PREADY_O          = pready_q;
    assign PRDATA_O          = prdata_q;
    assign PSLVERR_O         = pslverr_q;
    assign LAM_ACTIVE_O      = act_q;
    assign SAFE_TORQUE_OFF_O = sto_q;
    assign SAFE_STOP_ONE_O   = ss1_q;
    assign FAIL_SAFE_O       = fault_q;

    // ------------------------------------------------------------------
    // Assertions.
    // ------------------------------------------------------------------
    default clocking cb @(posedge CLOCK_I);
    endclocking
    default disable iff (SYS_RST_I);

    a_step_spacing: assert property (CE_I & tick |=> !tick)
        else $error("step tick repeated");
    a_limit_index: assert property (st_q == ST_RDUP |-> raddr == {sel_s, 1'b0})
        else $error("wrong limit set addressed");
    a_act_both: assert property (CE_I & act_a_s & act_b_s |=> act_q)
        else $error("not active with both inputs high");
    a_status_nine: assert property (CE_I |=> status_q[STAT_LAM] == $past(act_q))
        else $error("status bit 9 wrong");
    a_react_kind: assert property (CE_I & viol & !err_ss1_q |=> SAFE_TORQUE_OFF_O)
        else $error("torque off missing");
    a_deact_time: assert property (CE_I & !act_a_s & !bus_act_q |=> !act_q)
        else $error("deactivation late");
    a_log_fail: assert property (CE_I & viol |=> log0_q.status[STAT_FAIL] && log0_q.speed == $past(cur_spd_q))
        else $error("trigger record wrong");
    a_stamp_step: assert property (CE_I & tick |=> ts_q == $past(ts_q) + STEP_SLOTS)
        else $error("time stamp step wrong");
    a_log_posmin: assert property (CE_I & viol |=> log1_q.pos == POS_MIN && log1_q.speed == $past(prev_spd_q))
        else $error("earlier record wrong");
    a_prev_update: assert property (CE_I & st_q == ST_CHECK |=> prev_spd_q == $past(cur_spd_q))
        else $error("previous sample not stored");

    c_violation: cover property (viol);
    c_ss1_react: cover property (viol & err_ss1_q);
    c_bus_active: cover property (bus_act_q & !act_a_s ##1 act_q);
endmodule

// *** alm_drive_model.sv ***
// Behavioural model of the speed source and the two activation channels.
module alm_drive_model
    import alm_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        slow_i,
    input  wire logic [1:0]  act_i,
    input  wire logic [31:0] spd_i,
    input  wire logic [31:0] pos_i,
    output logic             act_a_o,
    output logic             act_b_o,
    output logic      [31:0] speed_o,
    output logic      [31:0] pos_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------------
    // Channel lag.
    // ------------------------------------------------------------------
    // A slow contact settles eight cycles late, so activation timing is not tied to one latency.
    logic [3:0] lag_q;
    logic [3:0] lag_d;

    always_comb begin
        lag_d = (act_i == {act_b_o, act_a_o}) ? 4'h0 : lag_q + 4'h1;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lag_q   <= 4'h0;
            act_a_o <= 1'b0;
            act_b_o <= 1'b0;
            speed_o <= 32'h0000_0000;
            pos_o   <= 32'h0000_0000;
        end else begin
            lag_q   <= lag_d;
            speed_o <= spd_i;
            pos_o   <= pos_i;
            if (!slow_i || lag_q == 4'h8) begin
                {act_b_o, act_a_o} <= act_i;
            end
        end
    end
endmodule

// *** tb.sv ***
// Self-checking testbench of the acceleration limit monitor.
module tb
    import alm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned STEP = 16;
    logic clk, rst, psel, pen, pwr, pready, pslverr, lam, safe_torque_off, ss1o, fsafe, slow, act_a, act_b;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, spd_cmd, pos_cmd, speed, pos, last_rd;
    logic [2:0]  sel;
    logic [1:0]  act_cmd;
    logic [33:0] expq[$];
    string       nmq[$];
    logic [33:0] ent;
    string       nm;
    logic [31:0] up[8];
    logic [31:0] lo[8];
    int          num_errors, n_checks, seed;

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    alm_accel_mon #(.STEP_CYC(STEP)) dut_u (.CLOCK_I(clk), .SYS_RST_I(rst), .CE_I(1'b1), .PSEL_I(psel),
        .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PREADY_O(pready),
        .PRDATA_O(prdata), .PSLVERR_O(pslverr), .ACT_A_I(act_a), .ACT_B_I(act_b), .LIM_SEL_I(sel),
        .SPEED_I(speed), .POSITION_I(pos), .LAM_ACTIVE_O(lam), .SAFE_TORQUE_OFF_O(safe_torque_off),
        .SAFE_STOP_ONE_O(ss1o), .FAIL_SAFE_O(fsafe));

    alm_drive_model model_u (.clk_i(clk), .rst_i(rst), .slow_i(slow), .act_i(act_cmd), .spd_i(spd_cmd),
        .pos_i(pos_cmd), .act_a_o(act_a), .act_b_o(act_b), .speed_o(speed), .pos_o(pos));

    // ------------------------------------------------------------------
    // Tasks.
    // ------------------------------------------------------------------
    task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", n, exp, seen);
        end
    endtask

    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    // Entered just after a rising edge; the request is held until pready is sampled high.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel   <= 1'b1;
        pen    <= 1'b0;
        pwr    <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        psel <= 1'b0;
        pen  <= 1'b0;
        @(posedge clk);
    endtask

    // Entry bit 33 marks a read whose value is only kept, bit 32 the expected error flag.
    task automatic rd(input string n, input logic [7:0] a, input logic [33:0] e);
        expq.push_back(e);
        nmq.push_back(n);
        apb(1'b0, a, 32'h0000_0000);
    endtask

    task automatic steps(input int n);
        repeat (n * STEP) @(posedge clk);
    endtask

    // ------------------------------------------------------------------
    // Read monitor.
    // ------------------------------------------------------------------
    always @(posedge clk) begin
        if (psel && pen && pready === 1'b1 && !pwr && expq.size() > 0) begin
            ent = expq.pop_front();
            nm  = nmq.pop_front();
            if (!ent[33]) begin
                chk(nm, prdata, ent[31:0]);
                chk({nm, " error"}, {31'b0, pslverr}, {31'b0, ent[32]});
            end
            last_rd = prdata;
        end
    end

    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        $display("BAD watchdog expected done seen hang");
        complete_run;
    end

    // ------------------------------------------------------------------
    // Main sequence.
    // ------------------------------------------------------------------
    initial begin
        logic signed [31:0] v0, nv, pr;
        logic [31:0] st;
        logic viol, ss, bus;
        int s;
        seed = 32'hbcfd_0ebf;
        {num_errors, n_checks} = '0;
        {rst, psel, pen, pwr, slow} = 5'b10000;
        {paddr, pwdata, spd_cmd, pos_cmd, sel, act_cmd} = '0;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd("status", OFS_STATUS, {2'b00, WORD_RST});
        rd("unmapped", 8'hF0, {2'b01, 32'h0000_0000});
        for (int k = 0; k < 8; k++) begin
            up[k] = 32'($random(seed) & 1023) + 32'h0000_0001;
            lo[k] = -(32'($random(seed) & 1023) + 32'h0000_0001);
            apb(1'b1, OFS_LIM_ADDR, 32'(2 * k));
            apb(1'b1, OFS_LIM_DATA, up[k]);
            apb(1'b1, OFS_LIM_ADDR, 32'(2 * k + 1));
            apb(1'b1, OFS_LIM_DATA, lo[k]);
        end
        for (int i = 0; i < 6; i++) begin
            s = $random(seed) & 7;
            case (i)
                0: begin v0 = 0; nv = up[s] + 1; end
                1: begin v0 = 5000; nv = v0 + lo[s] - 1; end
                2: begin v0 = -1000; nv = v0 - up[s] - 1; end
                3: begin v0 = 2000; nv = v0 + up[s]; end
                4: begin v0 = -5000; nv = v0 - lo[s] + 1; end
                default: begin v0 = -5000; nv = v0 + up[s] + 50; end
            endcase
            viol = i != 3 && i != 5;
            ss   = i == 1 || i == 4;
            bus  = i < 2 || i == 3;
            pr   = $random(seed);
            sel     <= s[2:0];
            slow    <= i == 2;
            act_cmd <= (i == 5) ? 2'b01 : (i >= 2) ? 2'b11 : 2'b00;
            spd_cmd <= v0;
            steps(2);
            apb(1'b1, OFS_CTRL, {29'b0, 1'b1, ss, bus});
            repeat (20) @(posedge clk);
            chk("active", {31'b0, lam}, {31'b0, i != 5});
            steps(1);
            pos_cmd <= pr;
            spd_cmd <= nv;
            steps(3);
            chk("torque off", {31'b0, safe_torque_off}, {31'b0, viol && !ss});
            chk("stop one", {31'b0, ss1o}, {31'b0, viol && ss});
            chk("fail safe", {31'b0, fsafe}, {31'b0, viol});
            st = (32'(viol) << 16) | (32'(i != 5) << 9) | (32'(viol && ss) << 2) | 32'(viol && !ss);
            rd("status", OFS_STATUS, {2'b00, st});
            if (viol) begin
                rd("rec0 pos", 8'h10, {2'b00, pr});
                rd("rec0 speed", 8'h14, {2'b00, nv});
                rd("rec0 time", 8'h18, {2'b10, 32'h0000_0000});
                chk("rec0 time step", {30'b0, last_rd[1:0]}, 32'h0000_0000);
                rd("rec1 time", 8'h28, {2'b00, last_rd - STEP_SLOTS});
                rd("rec0 status", 8'h1C, {2'b00, st & 32'h0001_0205});
                rd("rec1 pos", 8'h20, {2'b00, POS_MIN});
                rd("rec1 speed", 8'h24, {2'b00, v0});
            end
            $display("case %0d done", i);
        end
        complete_run;
    end
endmodule
